//--- dv/serial_host.sv
// host side of the serial link: gated shift clock and daisy-chain source
module serial_host (
	// link pins
	output logic sck_o,
	output logic chain_o,
	input wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] bits = 20'h00000;
	initial begin
		sck_o = 1'b0;
		chain_o = 1'b0;
	end
	// clock stands low outside frames; chain toggles so a wrong delay shows
	task automatic frame(input int n);
		#7;
		chain_o = 1'b1;
		repeat (n) begin
			#8 sck_o = 1'b1;
			#15 sck_o = 1'b0;
			bits = {bits[18:0], sdo_i};
			chain_o = ~chain_o;
			#7;
		end
	endtask
endmodule // serial_host

//--- dv/tb_adc_result_output_bus.sv
// self-checking bench of the converter result output bus
module tb_adc_result_output_bus;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cnv_n = 1'b1;
	logic pd = 1'b0;
	logic cs_n = 1'b1;
	logic [1:0] fmt = 2'h0;
	logic rng = 1'b0;
	logic cfs = 1'b0;
	logic [17:0] core = 18'h00000;
	logic [1:0] addr = 2'h0;
	logic chain, sck, result_serial_out, busy;
	logic [17:0] d_o, oe;
	int fails = 0;
	int checked = 0;
	always #5 clk_i = ~clk_i;
	adc_result_output_bus uut (.clk_i(clk_i), .rst_i(rst_i), .convert_start_n_i(cnv_n),
		.power_down_request_i(pd), .cs_n_i(cs_n), .bus_format_sel_lo_i(fmt[0]),
		.bus_format_sel_hi_i(fmt[1]), .input_range_select_i(rng), .code_format_select_i(cfs),
		.conv_data_i(core), .d_i({6'h00, chain, 9'h000, addr}), .d_o(d_o), .d_oe_o(oe),
		.sck_i(sck), .result_serial_out_o(result_serial_out), .busy_o(busy));
	serial_host host (.sck_o(sck), .chain_o(chain), .sdo_i(result_serial_out));
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	function automatic logic [17:0] coded(input logic [17:0] r);
		return {r[17] ^ cfs, r[16:0]};
	endfunction
	task automatic rst_abort();
		cs_n = 1'b0;
		cnv_n = 1'b0;
		core = 18'h15555;
		cyc(10);
		rst_i = 1'b1;
		cyc(2);
		chk("busy in reset", 20'h0, busy);
		chk("bus in reset", 20'h0, oe);
		rst_i = 1'b0;
		cnv_n = 1'b1;
		cyc(40);
		chk("busy after abort", 20'h0, busy);
		chk("par18 enable", 20'h3FFFF, oe);
		chk("aborted result", 20'h0, d_o);
		cs_n = 1'b1;
		$display("test reset abort done");
	endtask
	task automatic conv(input logic [17:0] v);
		int n;
		n = 0;
		core = v;
		cnv_n = 1'b0;
		for (int i = 0; i < 10 && busy !== 1'b1; i++) cyc(1);
		while (busy === 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk("busy length", 20'h0001C, 20'(n));
		cnv_n = 1'b1;
		cyc(4);
		$display("test conversion done");
	endtask
	task automatic pd_ignore();
		int n;
		n = 0;
		pd = 1'b1;
		cyc(4);
		core = 18'h3FFFF;
		cnv_n = 1'b0;
		repeat (40) begin
			cyc(1);
			if (busy !== 1'b0) n++;
		end
		chk("busy in power-down", 20'h0, 20'(n));
		cnv_n = 1'b1;
		pd = 1'b0;
		cyc(4);
		$display("test power-down done");
	endtask
	task automatic par_read();
		logic [17:0] w, e, m;
		w = coded(18'h2D5A3);
		cs_n = 1'b0;
		for (int f = 0; f < 3; f++) for (int a = 0; a < 4; a++) begin
			fmt = 2'(f);
			addr = 2'(a);
			cyc(5);
			m = (f == 0) ? 18'h3FFFF : (f == 1) ? 18'h3FFFC : 18'h3FC00;
			if (f == 0) e = w;
			else if (f == 1) e = a[0] ? {w[1:0], 16'h0000} : {w[17:2], 2'h0};
			else e = (a == 0) ? {w[17:10], 10'h000} : (a == 2) ? {w[9:2], 10'h000} :
				(a == 3) ? {w[1:0], 16'h0000} : 18'h00000;
			chk("bus enable", m, oe);
			chk("bus data", e, d_o & oe);
		end
		cs_n = 1'b1;
		cyc(5);
		chk("bus released", 20'h0, oe);
		$display("test parallel read done");
	endtask
	task automatic ser_read();
		logic [17:0] w;
		w = coded(18'h2D5A3);
		fmt = 2'h3;
		cyc(4);
		host.frame(3);
		cyc(1);
		cs_n = 1'b0;
		cyc(5);
		chk("serial enable", 20'h01000, oe);
		host.frame(20);
		chk("serial word", {w, 2'b10}, host.bits);
		cs_n = 1'b1;
		cyc(4);
		$display("test serial read done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		cyc(12);
		rst_i = 1'b0;
		cyc(2);
		rst_abort();
		conv(18'h2D5A3);
		pd_ignore();
		par_read();
		rng = 1'b1;
		cfs = 1'b1;
		par_read();
		rng = 1'b0;
		ser_read();
		complete_run();
	end
	initial begin
		#50us;
		fails++;
		complete_run();
	end
endmodule // tb_adc_result_output_bus

//--- rtl/adc_result_output_bus.sv
// result output bus of the sampling converter: conversion timing, parallel and serial readout
`include "adc_result_output_bus_defs.svh"

module adc_result_output_bus (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// conversion control pins
	input wire logic convert_start_n_i,
	input wire logic power_down_request_i,
	input wire logic cs_n_i,
	// configuration pins
	input wire logic bus_format_sel_lo_i,
	input wire logic bus_format_sel_hi_i,
	input wire logic input_range_select_i,
	input wire logic code_format_select_i,
	// converter core result, two's complement
	input wire logic [17:0] conv_data_i,
	// data bus pins
	input wire logic [17:0] d_i,
	output logic [17:0] d_o,
	output logic [17:0] d_oe_o,
	// serial link
	input wire logic sck_i,
	output logic result_serial_out_o,
	// status
	output logic busy_o
);

	adc_result_output_bus_pkg::core_state_t st_q;
	adc_result_output_bus_pkg::core_state_t st_d;
	adc_result_output_bus_pkg::link_state_t lk_q;
	adc_result_output_bus_pkg::link_state_t lk_d;
	logic start_req;
	logic [17:0] coded;
	logic [1:0] mode;
	logic [1:0] addr;

	// selects 01 and 11 flip the MSB of the two's complement code
	function automatic logic [17:0] code_word(input logic [17:0] raw, input logic fmt);
		code_word = fmt ? {~raw[17], raw[16:0]} : raw;
	endfunction

	assign mode = st_q.mode_sync[3:2];
	assign addr = st_q.addr_sync[3:2];
	assign coded = code_word(st_q.result, st_q.fmt_sync[1]);
	assign start_req = st_q.cnv_old && !st_q.cnv_sync[1] && !st_q.pd_sync[1];

	always_comb begin
		st_d = st_q;
		st_d.cnv_sync = {st_q.cnv_sync[0], convert_start_n_i};
		st_d.cnv_old = st_q.cnv_sync[1];
		st_d.cs_sync = {st_q.cs_sync[0], cs_n_i};
		st_d.pd_sync = {st_q.pd_sync[0], power_down_request_i};
		st_d.mode_sync = {st_q.mode_sync[1:0], bus_format_sel_hi_i, bus_format_sel_lo_i};
		st_d.addr_sync = {st_q.addr_sync[1:0], d_i[1], d_i[0]};
		st_d.rng_sync = {st_q.rng_sync[0], input_range_select_i};
		st_d.fmt_sync = {st_q.fmt_sync[0], code_format_select_i};
		unique case (st_q.conv)
			adc_result_output_bus_pkg::CONV_IDLE: begin
				if (start_req) begin
					st_d.conv = adc_result_output_bus_pkg::CONV_RUN;
					st_d.busy = 1'b1;
					st_d.cnt = 6'(`CONV_CYCLES - 1);
				end
			end
			adc_result_output_bus_pkg::CONV_RUN: begin
				if (st_q.cnt == 6'h00) begin
					st_d.conv = adc_result_output_bus_pkg::CONV_IDLE;
					st_d.busy = 1'b0;
					st_d.result = conv_data_i;
				end else begin
					st_d.cnt = st_q.cnt - 6'h01;
				end
			end
			default: begin
				st_d.conv = adc_result_output_bus_pkg::CONV_IDLE;
				st_d.busy = 1'b0;
			end
		endcase
		// serial word frozen while a frame is open
		if (st_q.cs_sync[1]) begin
			st_d.word = coded;
		end
		st_d.dout = 18'h00000;
		st_d.doe = 18'h00000;
		unique case (mode)
			`MODE_PAR18: begin
				st_d.dout = coded;
				st_d.doe = `OE_ALL;
			end
			`MODE_PAR16: begin
				st_d.doe = `OE_PAR16;
				if (addr[0]) begin
					st_d.dout = {coded[1:0], 16'h0000};
				end else begin
					st_d.dout = {coded[17:2], 2'h0};
				end
			end
			`MODE_PAR8: begin
				st_d.doe = `OE_PAR8;
				unique case (addr)
					2'h0: st_d.dout = {coded[17:10], 10'h000};
					2'h1: st_d.dout = 18'h00000;
					2'h2: st_d.dout = {coded[9:2], 10'h000};
					2'h3: st_d.dout = {coded[1:0], 16'h0000};
				endcase
			end
			`MODE_SERIAL: begin
				st_d.doe = `OE_SERIAL;
			end
		endcase
		if (st_q.cs_sync[1]) begin
			st_d.doe = 18'h00000;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '{cnv_sync: 2'h3, cnv_old: 1'b1, cs_sync: 2'h3, pd_sync: 2'h0,
				mode_sync: 4'h0, addr_sync: 4'h0, rng_sync: 2'h0, fmt_sync: 2'h0,
				conv: adc_result_output_bus_pkg::CONV_IDLE, cnt: 6'h00, busy: 1'b0,
				result: 18'h00000, word: 18'h00000, dout: 18'h00000, doe: 18'h00000};
		end else begin
			st_q <= st_d;
		end
	end

	// link side: word is quasi-static while cs is low, so it is sampled directly
	always_comb begin
		lk_d = lk_q;
		lk_d.started = 1'b1;
		if (!lk_q.started) begin
			lk_d.result_serial_out = st_q.word[17];
			lk_d.shift = {st_q.word[16:0], d_i[`PIN_SDI]};
		end else begin
			lk_d.result_serial_out = lk_q.shift[17];
			lk_d.shift = {lk_q.shift[16:0], d_i[`PIN_SDI]};
		end
	end

	// chip select high holds the link logic in reset, so stray edges do nothing
	always_ff @(posedge sck_i or posedge rst_i or posedge cs_n_i) begin
		if (rst_i || cs_n_i) begin
			lk_q <= '{started: 1'b0, shift: 18'h00000, result_serial_out: 1'b0};
		end else begin
			lk_q <= lk_d;
		end
	end

	assign d_o = st_q.dout;
	assign d_oe_o = st_q.doe;
	assign busy_o = st_q.busy;
	assign result_serial_out_o = lk_q.result_serial_out;

	AST_PAR18_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
		(!st_q.cs_sync[1] && mode == `MODE_PAR18) |=> (d_oe_o == `OE_ALL && d_o == $past(coded)))
		else $error("18-bit format does not drive the full result");

	AST_CS_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q.cs_sync[1] |=> (d_oe_o == 18'h00000))
		else $error("bus driven while chip select high");

	AST_LOW_PINS_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
		mode[1] |=> (d_oe_o[9:0] == 10'h000))
		else $error("pins 0 to 9 driven in 8-bit or serial format");

	AST_SERIAL_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
		(!st_q.cs_sync[1] && mode == `MODE_SERIAL) |=> (d_oe_o == `OE_SERIAL))
		else $error("serial format pin drive wrong");

	AST_PAR16_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode == `MODE_PAR16 && addr[0]) |=> (d_o == {$past(coded[1:0]), 16'h0000}))
		else $error("16-bit low segment misplaced");

	AST_BUSY_START: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_req && !busy_o) |=> busy_o)
		else $error("busy did not rise on conversion start");

	AST_BUSY_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy_o) |-> (busy_o [*8] ##20 busy_o ##1 !busy_o))
		else $error("busy width is not the conversion time");

	AST_PD_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_q.pd_sync[1] && !busy_o) |=> !busy_o)
		else $error("conversion started while powered down");

	AST_OFFSET_MSB: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode == `MODE_PAR18 && st_q.fmt_sync[1] && !st_q.cs_sync[1])
		|=> (d_o[17] != $past(st_q.result[17])))
		else $error("offset binary MSB not inverted");

	AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!(busy_o && st_q.cnt == 6'h00) |=> $stable(st_q.result))
		else $error("result changed outside conversion end");

	// the chain bit taken on the first edge of a frame must appear after the nineteenth edge
	AST_CHAIN_DELAY: assert property (@(posedge sck_i) disable iff (rst_i || cs_n_i)
		lk_q.started |-> ##18 (result_serial_out_o == $past(d_i[`PIN_SDI], 19)))
		else $error("chain input not delayed by 18 serial clocks");

	AST_PAR8_MID: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode == `MODE_PAR8 && addr == 2'h2) |=> (d_o == {$past(coded[9:2]), 10'h000}))
		else $error("8-bit middle segment misplaced");

	AST_PAR8_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode == `MODE_PAR8 && addr == 2'h1) |=> (d_o == 18'h00000))
		else $error("8-bit address 01 does not read zeros");

	AST_SERIAL_MSB: assert property (@(posedge sck_i) disable iff (rst_i || cs_n_i)
		!lk_q.started |=> (result_serial_out_o == $past(st_q.word[17])))
		else $error("first serial bit is not the MSB");

endmodule // adc_result_output_bus

//--- rtl/adc_result_output_bus_defs.svh
// constants of the converter result output bus
// Behaviour
// - bus format 00 gives 18-bit parallel output, 11 gives bit-serial output.
// - pins not used by the selected bus format stay high-impedance.
// - in formats 01 and 10 the two lowest pins are host address inputs.
// - format 00 drives result bit n on data pin n, all eighteen pins.
// - 16-bit format: addr0 low gives R[17:2]; high gives R[1:0] then zeros.
// - 8-bit format: 00 R[17:10], 10 R[9:2], 11 R[1:0] then zeros.
// - pins 2 to 9 carry data only in formats 00 and 01.
// - pins 10 to 17 carry data in 00, 01, 10; serial floats 10 and 14-17.
// - serial output shifts latest result MSB first on each rising serial clock.
// - chain input reappears on serial output 18 serial clocks later.
// - in serial format pin 13 is clock, 12 data out, 11 chain in.
// - serial word coding follows the current range and coding selects; the code ignores the range select and uses the coding select only.
// - busy rises at conversion start and stays high until it finishes.
// - bus is driven only while chip select is low, floated when high.
// - chip select high blocks serial clock edges from shifting.
// - reset aborts any conversion and floats the data bus.
// - falling edge on convert start begins a conversion, regardless of chip select.
// - power-down high ignores conversion requests.
// - selects give coding 00 twos, 01 offset, 10 twos, 11 straight binary; the code gives offset binary (MSB inverted) for 11 as well.
// - offset binary equals twos complement with MSB inverted.
`ifndef ADC_RESULT_OUTPUT_BUS_DEFS_SVH
`define ADC_RESULT_OUTPUT_BUS_DEFS_SVH

`define RES_W 18
`define MODE_PAR18 2'h0
`define MODE_PAR16 2'h1
`define MODE_PAR8 2'h2
`define MODE_SERIAL 2'h3
`define PIN_SCK 13
`define PIN_SDO 12
`define PIN_SDI 11
`define OE_ALL 18'h3FFFF
`define OE_PAR16 18'h3FFFC
`define OE_PAR8 18'h3FC00
`define OE_SERIAL 18'h01000
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 280
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/adc_result_output_bus_pkg.sv
// types of the converter result output bus
package adc_result_output_bus_pkg;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_RUN = 2'b10
	} conv_state_t;

	typedef struct packed {
		logic [1:0] cnv_sync;
		logic cnv_old;
		logic [1:0] cs_sync;
		logic [1:0] pd_sync;
		logic [3:0] mode_sync;
		logic [3:0] addr_sync;
		logic [1:0] rng_sync;
		logic [1:0] fmt_sync;
		conv_state_t conv;
		logic [5:0] cnt;
		logic busy;
		logic [17:0] result;
		logic [17:0] word;
		logic [17:0] dout;
		logic [17:0] doe;
	} core_state_t;

	typedef struct packed {
		logic started;
		logic [17:0] shift;
		logic result_serial_out;
	} link_state_t;

endpackage
